//--- hdl/pci_target_defs.vh
// constants for the pci target read prefetch path
`ifndef PCI_TARGET_DEFS_VH
`define PCI_TARGET_DEFS_VH
// target control register field positions
`define CTRL_DISCARD_BIT 19
`define CTRL_ONCE_BIT 12
`define CTRL_RESET 32'h0000_0000
// writable bits of the target control register
`define CTRL_MASK 32'h0008_1000
// byte step between consecutive words
`define ADDR_STEP 32'h0000_0004
// local side states
`define LS_IDLE 2'h0
`define LS_FILL 2'h1
`define LS_WRITE 2'h2
`endif

//--- hdl/word_fifo.v
// small flip-flop fifo used for both target fifos
`timescale 1ns/1ps
module word_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst_n,
  input wire flush,
  input wire push_valid,
  output wire push_ready,
  input wire [WIDTH-1:0] push_data,
  output wire pop_valid,
  input wire pop_ready,
  output wire [WIDTH-1:0] pop_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_push;
  wire do_pop;

  assign push_ready = (count != DEPTH[AW:0]);
  assign pop_valid = (count != {(AW+1){1'b0}});
  assign pop_data = mem[rd_ptr];
  assign do_push = push_valid & push_ready;
  assign do_pop = pop_ready & pop_valid;

  // ==========================================================
  // pointers and storage
  always @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                  : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                  : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end
endmodule

//--- hdl/pci_target_read_prefetch.v
// pci target data path: read prefetch fifo and posted write fifo
`timescale 1ns/1ps
`include "pci_target_defs.vh"
//
// Operation
// RULE_01 - bit 19 set discards leftover prefetched data after a transaction
// RULE_02 - control bit 12 clear streams local memory into the read fifo
// RULE_03 - bit 12 set: exactly one read fifo fill per read request
// RULE_04 - read with no fifo data is retried while filling continues
// RULE_05 - writes complete once accepted into the write fifo
// RULE_06 - posted writes wait while a read fifo fill is running
// RULE_07 - retried read finds data in fifo and completes normally
// RULE_08 - read data always comes from the master's own address
// RULE_09 - fill pointer follows the read stream, never write addresses
// RULE_10 - retained data reused only on an exactly sequential address
module pci_target_read_prefetch #(
  parameter RD_DEPTH = 8,
  parameter RD_AW = 3,
  parameter WR_DEPTH = 4,
  parameter WR_AW = 2
) (
  input wire CORE_CLK,
  input wire RST_N,
  input wire CTRL_WR,
  input wire [31:0] CTRL_WDATA,
  output reg [31:0] CTRL_RDATA,
  input wire REQ_VALID,
  input wire REQ_WRITE,
  input wire [31:0] REQ_ADDR,
  input wire [31:0] REQ_WDATA,
  output reg RSP_VALID,
  output reg RSP_RETRY,
  output reg [31:0] RSP_RDATA,
  output reg MEM_REQ,
  output reg MEM_WE,
  output reg [31:0] MEM_ADDR,
  output reg [31:0] MEM_WDATA,
  input wire MEM_ACK,
  input wire [31:0] MEM_RDATA
);
  // ==========================================================
  // state
  reg [31:0] target_control_register;
  reg [1:0] lstate;
  reg [31:0] fill_addr;
  reg [31:0] head_addr;
  reg fill_on;
  reg drop;
  wire read_fifo_discard_after_txn;
  wire read_fill_once_per_request;
  wire rd_req;
  wire wr_req;
  wire fill_busy;
  wire hit;
  wire waiting;
  wire restart;
  wire flush_rd;
  wire rf_push;
  wire rf_ready;
  wire rf_valid;
  wire [31:0] rf_data;
  wire wf_ready;
  wire wf_valid;
  wire wf_pop;
  wire [63:0] wf_data;
  wire want_fill;

  assign read_fifo_discard_after_txn =
    target_control_register[`CTRL_DISCARD_BIT];
  assign read_fill_once_per_request =
    target_control_register[`CTRL_ONCE_BIT];

  // ==========================================================
  // request decode
  assign rd_req = REQ_VALID & ~REQ_WRITE;
  assign wr_req = REQ_VALID & REQ_WRITE;
  assign fill_busy = (lstate == `LS_FILL);
  // head word must sit at exactly the requested address
  assign hit = rd_req & rf_valid & ~drop & (head_addr == REQ_ADDR); // RULE_10
  // fill already heading for this address: just retry
  assign waiting = rd_req & ~hit & ~drop & fill_on
                   & (head_addr == REQ_ADDR); // RULE_04
  // restart is held off during an outstanding fill so a late word can
  // never land in a fifo that now belongs to another address
  assign restart = rd_req & ~hit & ~waiting & ~fill_busy; // RULE_08
  assign flush_rd = restart | (drop & ~fill_busy); // RULE_01
  assign rf_push = fill_busy & MEM_ACK;
  assign want_fill = fill_on & rf_ready & ~flush_rd; // RULE_02
  assign wf_pop = (lstate == `LS_IDLE) & ~want_fill & wf_valid;

  // ==========================================================
  // fifos
  word_fifo #(
    .WIDTH(32),
    .DEPTH(RD_DEPTH),
    .AW(RD_AW)
  ) target_read_fifo (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .flush(flush_rd),
    .push_valid(rf_push),
    .push_ready(rf_ready),
    .push_data(MEM_RDATA),
    .pop_valid(rf_valid),
    .pop_ready(hit),
    .pop_data(rf_data)
  );

  word_fifo #(
    .WIDTH(64),
    .DEPTH(WR_DEPTH),
    .AW(WR_AW)
  ) target_write_fifo (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .flush(1'b0),
    .push_valid(wr_req),
    .push_ready(wf_ready),
    .push_data({REQ_ADDR, REQ_WDATA}),
    .pop_valid(wf_valid),
    .pop_ready(wf_pop),
    .pop_data(wf_data)
  );

  // ==========================================================
  // control register
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      target_control_register <= `CTRL_RESET; // RULE_01 RULE_02
      CTRL_RDATA <= `CTRL_RESET;
    end else if (CTRL_WR) begin
      target_control_register <= CTRL_WDATA & `CTRL_MASK;
      CTRL_RDATA <= CTRL_WDATA & `CTRL_MASK;
    end
  end

  // ==========================================================
  // pci side answers
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      RSP_VALID <= 1'b0;
      RSP_RETRY <= 1'b0;
      RSP_RDATA <= 32'h0000_0000;
      head_addr <= 32'h0000_0000;
      drop <= 1'b0;
    end else begin
      RSP_VALID <= REQ_VALID;
      // write done as soon as it is in the write fifo
      RSP_RETRY <= (rd_req & ~hit) | (wr_req & ~wf_ready); // RULE_05 RULE_04
      if (hit) begin
        RSP_RDATA <= rf_data; // RULE_07
        head_addr <= head_addr + `ADDR_STEP;
      end else begin
        RSP_RDATA <= 32'h0000_0000;
      end
      if (restart) begin
        head_addr <= REQ_ADDR; // RULE_08
      end
      if (flush_rd) begin
        drop <= 1'b0;
      end else if (hit && read_fifo_discard_after_txn) begin
        drop <= 1'b1; // RULE_01
      end
    end
  end

  // ==========================================================
  // local memory side
  always @(posedge CORE_CLK) begin
    if (!RST_N) begin
      lstate <= `LS_IDLE;
      fill_addr <= 32'h0000_0000;
      fill_on <= 1'b0;
      MEM_REQ <= 1'b0;
      MEM_WE <= 1'b0;
      MEM_ADDR <= 32'h0000_0000;
      MEM_WDATA <= 32'h0000_0000;
    end else begin
      if (restart) begin
        fill_addr <= REQ_ADDR; // RULE_09
        fill_on <= 1'b1; // RULE_04
      end else if (hit && read_fifo_discard_after_txn) begin
        fill_on <= 1'b0; // RULE_01
      end
      case (lstate)
        `LS_IDLE: begin
          if (want_fill) begin
            lstate <= `LS_FILL;
            MEM_REQ <= 1'b1;
            MEM_WE <= 1'b0;
            MEM_ADDR <= fill_addr; // RULE_09
          end else if (wf_valid) begin
            // writes only go when no fill wants the bus
            lstate <= `LS_WRITE; // RULE_06
            MEM_REQ <= 1'b1;
            MEM_WE <= 1'b1;
            MEM_ADDR <= wf_data[63:32];
            MEM_WDATA <= wf_data[31:0];
          end
        end
        `LS_FILL: begin
          if (MEM_ACK) begin
            lstate <= `LS_IDLE;
            MEM_REQ <= 1'b0;
            // only the fill itself advances the read pointer
            fill_addr <= fill_addr + `ADDR_STEP; // RULE_09
            if (read_fill_once_per_request) begin
              fill_on <= 1'b0; // RULE_03
            end
            // streaming keeps fill_on set; a full fifo only pauses the fill
          end
        end
        `LS_WRITE: begin
          if (MEM_ACK) begin
            lstate <= `LS_IDLE;
            MEM_REQ <= 1'b0;
            MEM_WE <= 1'b0;
          end
        end
        default: begin
          lstate <= `LS_IDLE;
          MEM_REQ <= 1'b0;
          MEM_WE <= 1'b0;
        end
      endcase
    end
  end
endmodule

//--- dv/pci_target_read_prefetch_chk.sv
// checker on the target path ports
`timescale 1ns/1ps
module pci_target_read_prefetch_chk (
  input wire CORE_CLK,
  input wire RST_N,
  input wire CTRL_WR,
  input wire [31:0] CTRL_WDATA,
  input wire [31:0] CTRL_RDATA,
  input wire REQ_VALID,
  input wire REQ_WRITE,
  input wire [31:0] REQ_ADDR,
  input wire RSP_VALID,
  input wire RSP_RETRY,
  input wire [31:0] RSP_RDATA,
  input wire MEM_REQ,
  input wire MEM_WE,
  input wire [31:0] MEM_ADDR,
  input wire [31:0] MEM_WDATA,
  input wire MEM_ACK
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  rsp_on_time_a: assert property (REQ_VALID |=> RSP_VALID)
    else $error("answer late");
  rsp_no_stray_a: assert property (RSP_VALID |-> $past(REQ_VALID))
    else $error("answer without request");
  // model data is address based, so a stale pointer shows here
  read_addr_a: assert property (
    REQ_VALID && !REQ_WRITE ##1 !RSP_RETRY
    |-> RSP_RDATA == ($past(REQ_ADDR) ^ 32'h5a5a_0000))
    else $error("read data from wrong address");
  retry_empty_a: assert property (RSP_VALID && RSP_RETRY
    |-> RSP_RDATA == 32'h0) else $error("retry carries data");
  ctrl_mask_a: assert property (CTRL_WR
    |=> CTRL_RDATA == ($past(CTRL_WDATA) & 32'h0008_1000))
    else $error("control copy wrong");
  mem_hold_a: assert property (MEM_REQ && !MEM_ACK
    |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE))
    else $error("local cycle changed");
  mem_drop_a: assert property (MEM_ACK |=> !MEM_REQ)
    else $error("local cycle not ended");
  write_data_a: assert property (MEM_REQ && MEM_WE
    |-> MEM_WDATA == ~MEM_ADDR) else $error("write data mismatch");
endmodule

//--- dv/local_mem_model.sv
// local memory model answering the target's local cycles
`timescale 1ns/1ps
module local_mem_model (
  input wire CORE_CLK,
  input wire MEM_REQ,
  input wire MEM_WE,
  input wire [31:0] MEM_ADDR,
  input wire [3:0] lat,
  output reg MEM_ACK = 1'b0,
  output reg [31:0] MEM_RDATA = 32'h0
);
  reg [3:0] cnt = 4'h0;
  // data outside the ack cycle toggles so a stale sample never matches
  always @(posedge CORE_CLK) begin
    MEM_ACK <= 1'b0;
    MEM_RDATA <= ~MEM_RDATA;
    if (MEM_REQ && !MEM_ACK) begin
      cnt <= cnt + 4'h1;
      if (cnt >= lat) begin
        MEM_ACK <= 1'b1;
        MEM_RDATA <= MEM_WE ? ~MEM_RDATA : MEM_ADDR ^ 32'h5a5a_0000;
        cnt <= 4'h0;
      end
    end
  end
endmodule

//--- dv/pci_target_read_prefetch_tb_top.sv
// testbench for the pci target read prefetch path
`timescale 1ns/1ps
module pci_target_read_prefetch_tb_top;
  reg CORE_CLK = 1'b0;
  reg RST_N = 1'b0;
  reg CTRL_WR = 1'b0;
  reg [31:0] CTRL_WDATA = 32'h0;
  reg REQ_VALID = 1'b0;
  reg REQ_WRITE = 1'b0;
  reg [31:0] REQ_ADDR = 32'h0;
  wire [31:0] REQ_WDATA = ~REQ_ADDR;
  wire [31:0] CTRL_RDATA;
  wire [31:0] RSP_RDATA;
  wire [31:0] MEM_ADDR;
  wire [31:0] MEM_WDATA;
  wire [31:0] MEM_RDATA;
  wire RSP_VALID;
  wire RSP_RETRY;
  wire MEM_REQ;
  wire MEM_WE;
  wire MEM_ACK;
  reg [3:0] lat = 4'h6;
  // answer as it stood in the one cycle after the request
  reg got_valid = 1'b0;
  reg got_retry = 1'b0;
  reg [31:0] got_data = 32'h0;
  integer failures = 0;
  integer total_checks = 0;
  integer fills = 0;
  integer n0;
  pci_target_read_prefetch dut (
    .CORE_CLK(CORE_CLK),
    .RST_N(RST_N),
    .CTRL_WR(CTRL_WR),
    .CTRL_WDATA(CTRL_WDATA),
    .CTRL_RDATA(CTRL_RDATA),
    .REQ_VALID(REQ_VALID),
    .REQ_WRITE(REQ_WRITE),
    .REQ_ADDR(REQ_ADDR),
    .REQ_WDATA(REQ_WDATA),
    .RSP_VALID(RSP_VALID),
    .RSP_RETRY(RSP_RETRY),
    .RSP_RDATA(RSP_RDATA),
    .MEM_REQ(MEM_REQ),
    .MEM_WE(MEM_WE),
    .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA),
    .MEM_ACK(MEM_ACK),
    .MEM_RDATA(MEM_RDATA)
  );
  local_mem_model mem (
    .CORE_CLK(CORE_CLK),
    .MEM_REQ(MEM_REQ),
    .MEM_WE(MEM_WE),
    .MEM_ADDR(MEM_ADDR),
    .lat(lat),
    .MEM_ACK(MEM_ACK),
    .MEM_RDATA(MEM_RDATA)
  );
  initial forever #2 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) if (MEM_ACK && !MEM_WE) fills <= fills + 1;
  // ==========
  // tasks
  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("BAD %0s exp %h got %h", what, exp, got);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(negedge CORE_CLK);
  endtask
  task req(input w, input [31:0] a);
    begin
      @(negedge CORE_CLK);
      REQ_VALID = 1'b1;
      REQ_WRITE = w;
      REQ_ADDR = a;
      @(negedge CORE_CLK);
      // the answer stands for this one cycle only
      got_valid = RSP_VALID;
      got_retry = RSP_RETRY;
      got_data = RSP_RDATA;
      REQ_VALID = 1'b0;
      chk("answer valid", 32'h1, {31'h0, got_valid});
    end
  endtask
  // retries are bounded so a dead fill path cannot hang the run
  task rd(input [31:0] a, input first);
    integer n;
    begin
      req(1'b0, a);
      chk("first retry", {31'h0, first}, {31'h0, got_retry});
      for (n = 0; n < 60 && got_retry === 1'b1; n = n + 1)
        req(1'b0, a);
      chk("read retry", 32'h0, {31'h0, got_retry});
      chk("read data", a ^ 32'h5a5a_0000, got_data);
    end
  endtask
  task set_ctrl(input [31:0] v);
    begin
      @(negedge CORE_CLK);
      CTRL_WR = 1'b1;
      CTRL_WDATA = v;
      @(negedge CORE_CLK);
      CTRL_WR = 1'b0;
    end
  endtask
  task t_regs;
    begin
      chk("ctrl reset", 32'h0, CTRL_RDATA);
      set_ctrl(32'hffff_ffff);
      chk("ctrl mask", 32'h0008_1000, CTRL_RDATA);
      set_ctrl(32'h0);
    end
  endtask
  task t_post;
    integer a;
    begin
      req(1'b0, 32'h200);
      chk("miss", 32'h1, {31'h0, got_retry});
      req(1'b1, 32'h300);
      chk("posted", 32'h0, {31'h0, got_retry});
      rd(32'h200, 1'b1);
      idle(40);
      rd(32'h204, 1'b0);
      // long pause lets the posted write run between stream fills
      idle(120);
      for (a = 32'h208; a <= 32'h224; a = a + 4)
        rd(a, 1'b0);
      rd(32'h400, 1'b1);
    end
  endtask
  task t_once;
    begin
      set_ctrl(32'h0000_1000);
      idle(40);
      n0 = fills;
      rd(32'h800, 1'b1);
      idle(40);
      chk("fill count", 32'h1, fills - n0);
    end
  endtask
  task t_discard;
    begin
      set_ctrl(32'h0008_0000);
      idle(40);
      rd(32'ha00, 1'b1);
      idle(40);
      rd(32'ha04, 1'b1);
    end
  endtask
  task t_reset;
    begin
      set_ctrl(32'h0);
      rd(32'hc00, 1'b1);
      idle(40);
      set_ctrl(32'h0000_1000);
      @(negedge CORE_CLK);
      RST_N = 1'b0;
      idle(2);
      chk("ctrl after reset", 32'h0, CTRL_RDATA);
      chk("local req after reset", 32'h0, {31'h0, MEM_REQ});
      RST_N = 1'b1;
      // without the reset this word would hit the retained data
      rd(32'hc04, 1'b1);
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    RST_N = 1'b1;
    t_regs;
    t_post;
    t_once;
    lat = 4'h0;
    t_discard;
    t_reset;
    stop_test;
  end
  initial begin
    #40000;
    failures = failures + 1;
    stop_test;
  end
endmodule
bind pci_target_read_prefetch pci_target_read_prefetch_chk chk_i (
  .CORE_CLK(CORE_CLK),
  .RST_N(RST_N),
  .CTRL_WR(CTRL_WR),
  .CTRL_WDATA(CTRL_WDATA),
  .CTRL_RDATA(CTRL_RDATA),
  .REQ_VALID(REQ_VALID),
  .REQ_WRITE(REQ_WRITE),
  .REQ_ADDR(REQ_ADDR),
  .RSP_VALID(RSP_VALID),
  .RSP_RETRY(RSP_RETRY),
  .RSP_RDATA(RSP_RDATA),
  .MEM_REQ(MEM_REQ),
  .MEM_WE(MEM_WE),
  .MEM_ADDR(MEM_ADDR),
  .MEM_WDATA(MEM_WDATA),
  .MEM_ACK(MEM_ACK)
);
